// ===== hw/pmcc_div.sv
// rate divider: half-rate and reduced-rate enable pulses
`timescale 1ns/10ps
`default_nettype none
module pmcc_div #(
  parameter int CNT_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  pmcc_clk_if.div_mp cif
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] rf_mask;
  logic [CNT_W-1:0] rfh_mask;

  always_comb begin
    cnt_nxt = cnt_r + 1'b1;
    rf_mask = CNT_W'((1 << cif.rf_sel) - 1);
    rfh_mask = CNT_W'((2 << cif.rf_sel) - 1);
  end

  // ==========================================================
  // counter runs free; a new divisor applies on the next edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      cif.half_en <= 1'b0;
      cif.rf_en <= 1'b0;
      cif.rf_half_en <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      cif.half_en <= ~cnt_nxt[0];
      cif.rf_en <= (cnt_nxt & rf_mask) == '0;
      cif.rf_half_en <= (cnt_nxt & rfh_mask) == '0;
    end
  end

endmodule : pmcc_div
`default_nettype wire

// ===== hw/pmcc_top.sv
// power-mode clock controller: modes, clock gating, bus release, apb registers
`timescale 1ns/10ps
`default_nettype none
module pmcc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic xtal_ref,
  output logic pll_locked,
  input wire logic periph_int,
  input wire logic [7:0] ext_int,
  input wire logic nmi,
  input wire logic int_masked,
  input wire logic wbuf_empty,
  input wire logic general_bus_request,
  input wire logic high_priority_general_request,
  input wire logic snoop_bus_request,
  input wire logic high_priority_snoop_request,
  output logic general_bus_grant,
  output logic high_priority_general_grant,
  output logic snoop_bus_grant,
  output logic high_priority_snoop_grant,
  output logic core_exception_req,
  output logic core_resume_req,
  output logic system_clock_run,
  output logic core_pipe_clk_en,
  output logic core_snoop_clk_en,
  output logic core_int_clk_en,
  output logic wbuf_clk_en,
  output logic dram_refresh_clk_en,
  output logic dram_ctl_clk_en,
  output logic rom_clk_en,
  output logic dma_clk_en,
  output logic irc_clk_en,
  output logic serial_baud_clk_en,
  output logic serial_clk_en,
  output logic timer_cnt_clk_en,
  output logic timer_clk_en,
  output logic parallel_clk_en,
  output logic halt_active,
  output logic doze_active
);

  // ==========================================================
  // sub-blocks
  pmcc_clk_if cif ();

  pmcc_div pmcc_div_inst (
    .pclk(pclk),
    .presetn(presetn),
    .cif(cif.div_mp)
  );

  pmcc_wake pmcc_wake_inst (
    .pclk(pclk),
    .presetn(presetn),
    .cif(cif.wake_mp)
  );

  logic [31:0] cfg_r;
  pmcc_pkg::pmcc_mode_t mode_r;
  pmcc_pkg::pmcc_mode_t mode_nxt;
  logic [3:0] gnt_r;
  logic [3:0] gnt_nxt;
  logic [3:0] req_ok;
  logic snp_ok;
  logic [3:0] ref_cnt_r;
  logic ref_prev_r;
  logic ref_rise;
  logic apb_setup;
  logic apb_wr_cfg;
  logic addr_hit;
  logic [31:0] rd_val;
  logic [15:0] gate_vec;

  assign cif.rf_sel = cfg_r[pmcc_pkg::RF_LSB +: pmcc_pkg::RF_W];
  assign cif.ext_int = ext_int;
  assign cif.periph_int = periph_int;
  assign cif.nmi = nmi;
  assign cif.int_masked = int_masked;
  assign cif.asleep = (mode_r != pmcc_pkg::PMCC_NORMAL);

  // ==========================================================
  // pll lock monitor: four system clocks per reference period
  assign ref_rise = xtal_ref & ~ref_prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_prev_r <= 1'b0;
      ref_cnt_r <= 4'h0;
      pll_locked <= 1'b0;
    end else begin
      ref_prev_r <= xtal_ref;
      if (ref_rise) begin
        ref_cnt_r <= 4'h0;
        pll_locked <= (ref_cnt_r == pmcc_pkg::PLL_LOCK_CNT);
      end else if (ref_cnt_r != 4'hf) begin
        ref_cnt_r <= ref_cnt_r + 4'h1;
      end
    end
  end

  // ==========================================================
  // apb slave: zero wait, read data captured in setup phase
  assign apb_setup = psel & ~penable;
  assign apb_wr_cfg = psel & penable & pwrite & (paddr == pmcc_pkg::OFF_CFG);
  assign addr_hit = (paddr == pmcc_pkg::OFF_CFG) | (paddr == pmcc_pkg::OFF_STAT) |
                    (paddr == pmcc_pkg::OFF_GATE);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

  assign gate_vec = {system_clock_run, core_pipe_clk_en, core_snoop_clk_en, core_int_clk_en,
                     wbuf_clk_en, dram_refresh_clk_en, dram_ctl_clk_en, rom_clk_en,
                     dma_clk_en, irc_clk_en, serial_baud_clk_en, serial_clk_en,
                     timer_cnt_clk_en, timer_clk_en, parallel_clk_en, 1'b0};

  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr)
      pmcc_pkg::OFF_CFG: rd_val = cfg_r;
      pmcc_pkg::OFF_STAT: rd_val = {20'h0_0000, gnt_r, 1'b0, wbuf_empty, pll_locked, 2'h0, mode_r};
      pmcc_pkg::OFF_GATE: rd_val = {16'h0000, gate_vec};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      prdata <= rd_val;
    end
  end

  // ==========================================================
  // configuration register; a store that sets a sleep bit wins
  // over a wake in the same cycle, the wake source being a level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= pmcc_pkg::CFG_RST;
    end else if (apb_wr_cfg) begin
      cfg_r <= pwdata & pmcc_pkg::CFG_WMASK;
    end else if (cif.wake_pulse) begin
      cfg_r[pmcc_pkg::HALT_BIT] <= 1'b0;
      cfg_r[pmcc_pkg::DOZE_BIT] <= 1'b0;
    end
  end

  // ==========================================================
  // mode state machine; halt has priority over doze
  always_comb begin
    case (mode_r)
      pmcc_pkg::PMCC_NORMAL: begin
        if (cfg_r[pmcc_pkg::HALT_BIT]) begin
          mode_nxt = pmcc_pkg::PMCC_HALT;
        end else if (cfg_r[pmcc_pkg::DOZE_BIT]) begin
          mode_nxt = pmcc_pkg::PMCC_DOZE;
        end else begin
          mode_nxt = pmcc_pkg::PMCC_NORMAL;
        end
      end
      pmcc_pkg::PMCC_DOZE: begin
        if (cif.wake_pulse || !cfg_r[pmcc_pkg::DOZE_BIT]) begin
          mode_nxt = pmcc_pkg::PMCC_NORMAL;
        end else if (cfg_r[pmcc_pkg::HALT_BIT]) begin
          mode_nxt = pmcc_pkg::PMCC_HALT;
        end else begin
          mode_nxt = pmcc_pkg::PMCC_DOZE;
        end
      end
      pmcc_pkg::PMCC_HALT: begin
        if (cif.wake_pulse || !cfg_r[pmcc_pkg::HALT_BIT]) begin
          mode_nxt = pmcc_pkg::PMCC_NORMAL;
        end else begin
          mode_nxt = pmcc_pkg::PMCC_HALT;
        end
      end
      default: mode_nxt = pmcc_pkg::PMCC_NORMAL;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= pmcc_pkg::PMCC_NORMAL;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  assign halt_active = (mode_r == pmcc_pkg::PMCC_HALT);
  assign doze_active = (mode_r == pmcc_pkg::PMCC_DOZE);

  // ==========================================================
  // wake outcome to the core; halt assumes interrupts unmasked,
  // so it always ends in an exception
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_exception_req <= 1'b0;
      core_resume_req <= 1'b0;
    end else begin
      core_exception_req <= cif.wake_pulse & (halt_active | cif.wake_exc);
      core_resume_req <= cif.wake_pulse & doze_active & cif.wake_resume;
    end
  end

  // ==========================================================
  // bus release arbiter; grant bits {hp snoop, hp general, snoop, general}
  always_comb begin
    snp_ok = ~halt_active;
    req_ok = {high_priority_snoop_request & snp_ok, high_priority_general_request,
              snoop_bus_request & snp_ok, general_bus_request};
    gnt_nxt = gnt_r & req_ok;
    if (gnt_nxt == 4'h0) begin
      if (req_ok[3]) begin
        gnt_nxt = 4'h8;
      end else if (req_ok[2]) begin
        gnt_nxt = 4'h4;
      end else if (req_ok[1]) begin
        gnt_nxt = 4'h2;
      end else if (req_ok[0]) begin
        gnt_nxt = 4'h1;
      end else begin
        gnt_nxt = 4'h0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gnt_r <= 4'h0;
    end else begin
      gnt_r <= gnt_nxt;
    end
  end

  assign high_priority_snoop_grant = gnt_r[3];
  assign high_priority_general_grant = gnt_r[2];
  assign snoop_bus_grant = gnt_r[1];
  assign general_bus_grant = gnt_r[0];

  // ==========================================================
  // clock gating enables, all registered so they only move on an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_clock_run <= 1'b0;
      core_pipe_clk_en <= 1'b0;
      core_snoop_clk_en <= 1'b0;
      core_int_clk_en <= 1'b0;
      wbuf_clk_en <= 1'b0;
      dram_refresh_clk_en <= 1'b0;
      dram_ctl_clk_en <= 1'b0;
      rom_clk_en <= 1'b0;
      dma_clk_en <= 1'b0;
      irc_clk_en <= 1'b0;
      serial_baud_clk_en <= 1'b0;
      serial_clk_en <= 1'b0;
      timer_cnt_clk_en <= 1'b0;
      timer_clk_en <= 1'b0;
      parallel_clk_en <= 1'b0;
    end else begin
      system_clock_run <= 1'b1;
      core_pipe_clk_en <= cif.rf_en & (mode_r == pmcc_pkg::PMCC_NORMAL);
      core_snoop_clk_en <= cif.rf_en & ~halt_active;
      core_int_clk_en <= cif.rf_en;
      wbuf_clk_en <= cif.rf_en & (~cif.asleep | ~wbuf_empty);
      dram_refresh_clk_en <= ~(halt_active & cfg_r[pmcc_pkg::SREF_BIT]);
      dram_ctl_clk_en <= cif.rf_en & ~halt_active;
      rom_clk_en <= cif.rf_en & ~halt_active;
      dma_clk_en <= cif.rf_en & ~halt_active;
      irc_clk_en <= cif.rf_en;
      serial_baud_clk_en <= cif.half_en;
      serial_clk_en <= cif.rf_half_en;
      timer_cnt_clk_en <= cif.half_en;
      timer_clk_en <= cif.rf_half_en;
      parallel_clk_en <= cif.rf_half_en & ~halt_active;
    end
  end

  // ==========================================================
  // assertions
  // armed one clock after reset release, so that no attempt started
  // on the releasing edge sees the reset values of the enables
  logic arm_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_r <= 1'b0;
    end else begin
      arm_r <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!arm_r);

  a_pll_lock_seen: assert property (ref_rise && ref_cnt_r == 4'h3 |=> pll_locked)
    else $error("pll lock not flagged after four clocks");

  a_full_rate_mem: assert property (
    (cif.rf_sel == 2'h0)[*2] ##0 !halt_active |=> dma_clk_en && rom_clk_en && dram_ctl_clk_en)
    else $error("memory and dma clocks not at full rate");

  a_half_rate_timer: assert property (timer_cnt_clk_en |=> !timer_cnt_clk_en)
    else $error("timer count clock faster than half rate");

  a_halt_entry: assert property (
    apb_wr_cfg && pwdata[pmcc_pkg::HALT_BIT] && !cif.asleep |=> ##1 halt_active ##1 !core_pipe_clk_en)
    else $error("halt bit did not stop core clock");

  a_halt_no_snoop: assert property (halt_active |=> !snoop_bus_grant && !high_priority_snoop_grant)
    else $error("snoop release granted in halt");

  a_halt_general: assert property (
    halt_active && general_bus_request && gnt_r == 4'h0 && !high_priority_general_request
    |=> general_bus_grant)
    else $error("general release refused in halt");

  a_system_clock_run: assert property (1'b1 |=> system_clock_run)
    else $error("system clock stopped");

  a_wbuf_drain: assert property (
    (cif.asleep && !wbuf_empty && cif.rf_en) |=> wbuf_clk_en)
    else $error("write buffer clock stopped while not empty");

  a_wake_clears: assert property (
    cif.wake_pulse && !apb_wr_cfg |=> !cfg_r[pmcc_pkg::HALT_BIT] && !cfg_r[pmcc_pkg::DOZE_BIT] && !cif.asleep)
    else $error("wake did not clear sleep bits next cycle");

  a_halt_wake_exc: assert property (cif.wake_pulse && halt_active |=> core_exception_req)
    else $error("halt wake without exception");

  a_doze_resume: assert property (
    cif.wake_pulse && doze_active && cif.wake_resume |=> core_resume_req && !core_exception_req)
    else $error("masked doze wake did not resume");

  a_doze_periph: assert property (
    doze_active && cif.rf_en |=> !core_pipe_clk_en && core_snoop_clk_en && dma_clk_en && rom_clk_en)
    else $error("doze gating wrong");

  a_halt_gating: assert property (
    halt_active |=> !rom_clk_en && !dma_clk_en && !parallel_clk_en && !dram_ctl_clk_en && !core_snoop_clk_en)
    else $error("halted block still clocked");

  a_refresh_keep: assert property (
    !(halt_active && cfg_r[pmcc_pkg::SREF_BIT]) |=> dram_refresh_clk_en)
    else $error("refresh clock stopped");

  c_halt_wake: cover property (halt_active ##1 cif.wake_pulse ##1 core_exception_req);
  c_doze_resume: cover property (doze_active ##1 core_resume_req);
  c_snoop_grant: cover property (doze_active && high_priority_snoop_grant);
  c_pll_lock: cover property (!pll_locked ##1 pll_locked);

endmodule : pmcc_top
`default_nettype wire

// ===== hw/pmcc_wake.sv
// wake detector for doze and halt
`timescale 1ns/10ps
`default_nettype none
module pmcc_wake (
  input wire logic pclk,
  input wire logic presetn,
  pmcc_clk_if.wake_mp cif
);

  logic src;
  logic exc;

  always_comb begin
    src = cif.periph_int | (|cif.ext_int) | cif.nmi;
    exc = cif.nmi | ((cif.periph_int | (|cif.ext_int)) & ~cif.int_masked);
  end

  // ==========================================================
  // one pulse per wake; the guard stops a second pulse while the
  // controller is still leaving the sleep mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cif.wake_pulse <= 1'b0;
      cif.wake_exc <= 1'b0;
      cif.wake_resume <= 1'b0;
    end else begin
      cif.wake_pulse <= cif.asleep & src & ~cif.wake_pulse;
      cif.wake_exc <= exc;
      cif.wake_resume <= ~exc;
    end
  end

endmodule : pmcc_wake
`default_nettype wire

// ===== inc/pmcc_clk_if.sv
// internal carrier between the controller, its rate divider and its wake detector
`timescale 1ns/10ps
`default_nettype none
interface pmcc_clk_if;
  logic [pmcc_pkg::RF_W-1:0] rf_sel;
  logic half_en;
  logic rf_en;
  logic rf_half_en;
  logic [7:0] ext_int;
  logic periph_int;
  logic nmi;
  logic int_masked;
  logic asleep;
  logic wake_pulse;
  logic wake_exc;
  logic wake_resume;

  modport div_mp (input rf_sel, output half_en, output rf_en, output rf_half_en);
  modport wake_mp (input ext_int, input periph_int, input nmi, input int_masked, input asleep,
                   output wake_pulse, output wake_exc, output wake_resume);
endinterface : pmcc_clk_if
`default_nettype wire

// ===== inc/pmcc_pkg.sv
// constants and types of the power-mode clock controller
//
// Functional notes
// - system clock is crystal reference times four
// - memory/dma/irc full rate, timer/serial/parallel half
// - halt bit stops core pipe and snoop clocks, keeps pipeline
// - halt grants general requests, never snoop ones
// - write buffer drains in sleep; system clock runs
// - halt ends on any interrupt, nmi or reset
// - doze stops part of core, peripherals run
// - doze ends on same sources, mask untouched
// - masked doze wake resumes at next instruction
// - reduced frequency change takes effect immediately
// - refresh keeps full clock, baud and timer count keep half clock
// - per-block clock gating in doze and halt
// - self-refresh dram allows stopping refresh in halt
package pmcc_pkg;

  // ==========================================================
  // clock generation
  localparam int unsigned PLL_MULT = 4;
  localparam logic [3:0] PLL_LOCK_CNT = 4'(PLL_MULT - 1);
  localparam int unsigned CLK_PERIOD_NS = 25;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [11:0] OFF_CFG = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h004;
  localparam logic [11:0] OFF_GATE = 12'h008;

  // ==========================================================
  // configuration fields
  localparam int RF_LSB = 0;
  localparam int RF_W = 2;
  localparam int HALT_BIT = 8;
  localparam int DOZE_BIT = 9;
  localparam int SREF_BIT = 10;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_WMASK = 32'h0000_0703;

  // ==========================================================
  // operating modes
  typedef enum logic [2:0] {
    PMCC_NORMAL = 3'b001,
    PMCC_DOZE = 3'b010,
    PMCC_HALT = 3'b100
  } pmcc_mode_t;

endpackage : pmcc_pkg

// ===== tb/pmcc_core_model.sv
// partner model: crystal reference and the core's write buffer
`timescale 1ns/10ps
`default_nettype none
module pmcc_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wbuf_clk_en,
  input wire logic load_valid,
  input wire logic [3:0] load_cnt,
  output logic wbuf_empty,
  output logic xtal_ref
);
  logic [1:0] ph_r;
  logic [3:0] pend_r;
  // ==========================================================
  // crystal reference
  // a quarter of the system clock, so the lock monitor sees four edges per period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_r <= 2'h0;
    end else begin
      ph_r <= ph_r + 2'h1;
    end
  end
  assign xtal_ref = ph_r[1];
  // ==========================================================
  // write buffer
  // one pending word leaves per enabled clock, so a stopped enable stalls the drain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 4'h0;
    end else if (load_valid) begin
      pend_r <= load_cnt;
    end else if (wbuf_clk_en && pend_r != 4'h0) begin
      pend_r <= pend_r - 4'h1;
    end
  end
  assign wbuf_empty = (pend_r == 4'h0);
endmodule : pmcc_core_model
`default_nettype wire

// ===== tb/pmcc_top_bench.sv
// self-checking bench of the power-mode clock controller
`timescale 1ns/10ps
`default_nettype none
module pmcc_top_bench;
  typedef struct packed {
    logic [11:0] cfg;
    logic [3:0] req;
    logic [3:0] gnt;
    logic [2:0] mode;
    logic [3:0] gate;
  } pmcc_row_t;
  // gate column is {pipe, snoop, rom, dma}
  localparam pmcc_row_t ROWS [7] = '{
    '{12'h000, 4'h1, 4'h1, 3'h1, 4'hf}, '{12'h000, 4'hf, 4'h8, 3'h1, 4'hf},
    '{12'h000, 4'h6, 4'h4, 3'h1, 4'hf}, '{12'h200, 4'h2, 4'h2, 3'h2, 4'h7},
    '{12'h100, 4'h3, 4'h1, 3'h4, 4'h0}, '{12'h100, 4'hc, 4'h4, 3'h4, 4'h0},
    '{12'h100, 4'ha, 4'h0, 3'h4, 4'h0}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, xtal_ref, pll_locked, wbuf_empty, load_valid = 1'b0;
  logic periph_int = 1'b0, nmi = 1'b0, int_masked = 1'b0;
  logic [7:0] ext_int = 8'h00;
  logic [3:0] req = 4'h0, load_cnt = 4'h0, gnt;
  logic core_exception_req, core_resume_req, system_clock_run, core_pipe_clk_en, core_snoop_clk_en;
  logic core_int_clk_en, wbuf_clk_en, dram_refresh_clk_en, dram_ctl_clk_en, rom_clk_en, dma_clk_en;
  logic irc_clk_en, serial_baud_clk_en, serial_clk_en, timer_cnt_clk_en, timer_clk_en, parallel_clk_en;
  logic halt_active, doze_active;
  int miscompares = 0;
  int checks = 0;

  always #12.5 pclk = ~pclk;

  pmcc_top pmcc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .xtal_ref(xtal_ref),
    .pll_locked(pll_locked), .periph_int(periph_int), .ext_int(ext_int), .nmi(nmi), .int_masked(int_masked),
    .wbuf_empty(wbuf_empty), .general_bus_request(req[0]), .high_priority_general_request(req[2]),
    .snoop_bus_request(req[1]), .high_priority_snoop_request(req[3]), .general_bus_grant(gnt[0]),
    .high_priority_general_grant(gnt[2]), .snoop_bus_grant(gnt[1]), .high_priority_snoop_grant(gnt[3]),
    .core_exception_req(core_exception_req), .core_resume_req(core_resume_req),
    .system_clock_run(system_clock_run), .core_pipe_clk_en(core_pipe_clk_en),
    .core_snoop_clk_en(core_snoop_clk_en), .core_int_clk_en(core_int_clk_en), .wbuf_clk_en(wbuf_clk_en),
    .dram_refresh_clk_en(dram_refresh_clk_en), .dram_ctl_clk_en(dram_ctl_clk_en), .rom_clk_en(rom_clk_en),
    .dma_clk_en(dma_clk_en), .irc_clk_en(irc_clk_en), .serial_baud_clk_en(serial_baud_clk_en),
    .serial_clk_en(serial_clk_en), .timer_cnt_clk_en(timer_cnt_clk_en), .timer_clk_en(timer_clk_en),
    .parallel_clk_en(parallel_clk_en), .halt_active(halt_active), .doze_active(doze_active));

  pmcc_core_model pmcc_core_model_inst (.pclk(pclk), .presetn(presetn), .wbuf_clk_en(wbuf_clk_en),
    .load_valid(load_valid), .load_cnt(load_cnt), .wbuf_empty(wbuf_empty), .xtal_ref(xtal_ref));

  // ==========================================================
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // apb master
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cyc(input int n);
    repeat (n) @(negedge pclk);
  endtask : cyc

  // sleeps, raises one wake source and times the request pulse
  task automatic wake(input logic [11:0] cfg, input logic [2:0] src, input logic msk, input logic exc);
    int n;
    n = 0;
    apb(1'b1, pmcc_pkg::OFF_CFG, {20'h0, cfg});
    cyc(3);
    @(posedge pclk);
    {nmi, periph_int, ext_int[5]} <= src;
    int_masked <= msk;
    do begin
      @(negedge pclk);
      n++;
    end while (core_exception_req !== 1'b1 && core_resume_req !== 1'b1 && n < 8);
    chk(32'(n), 32'h3);
    chk(32'({core_exception_req, core_resume_req}), 32'({exc, ~exc}));
    chk(32'({halt_active, doze_active}), 32'h0);
    @(posedge pclk);
    {nmi, periph_int, ext_int[5]} <= 3'h0;
    int_masked <= 1'b0;
    $display("wake test done");
  endtask : wake

  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end

  initial begin
    int c_irc, c_tmr, c_cnt, c_ref, c_ser, c_par, c_bd;
    repeat (16) @(posedge pclk);
    chk(32'({pready, system_clock_run, halt_active, doze_active}), 32'h8);
    presetn <= 1'b1;
    cyc(20);
    chk(32'({system_clock_run, pll_locked}), 32'h3);
    $display("reset test done");
    apb(1'b0, pmcc_pkg::OFF_CFG, 32'h0);
    chk(rd, pmcc_pkg::CFG_RST);
    apb(1'b0, 12'h00c, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0000_0000);
    apb(1'b1, pmcc_pkg::OFF_CFG, 32'hffff_ffff);
    apb(1'b0, pmcc_pkg::OFF_CFG, 32'h0);
    chk(rd, pmcc_pkg::CFG_WMASK);
    $display("register test done");
    for (int i = 0; i < 7; i++) begin
      @(posedge pclk);
      req <= 4'h0;
      cyc(2);
      apb(1'b1, pmcc_pkg::OFF_CFG, {20'h0, ROWS[i].cfg});
      req <= ROWS[i].req;
      cyc(3);
      apb(1'b0, pmcc_pkg::OFF_STAT, 32'h0);
      chk(32'(rd[11:8]), 32'(ROWS[i].gnt));
      chk(32'(rd[2:0]), 32'(ROWS[i].mode));
      @(negedge pclk);
      chk(32'(gnt), 32'(ROWS[i].gnt));
      chk(32'({dram_ctl_clk_en, dma_clk_en}), 32'({2{ROWS[i].gate[0]}}));
      chk(32'({core_pipe_clk_en, core_snoop_clk_en, rom_clk_en, dma_clk_en}), 32'(ROWS[i].gate));
      chk(32'({system_clock_run, core_int_clk_en, irc_clk_en}), 32'h7);
      $display("row %0d done", i);
    end
    @(posedge pclk);
    req <= 4'h0;
    load_valid <= 1'b1;
    load_cnt <= 4'h9;
    @(posedge pclk);
    load_valid <= 1'b0;
    cyc(30);
    chk(32'({halt_active, wbuf_empty, wbuf_clk_en}), 32'h6);
    apb(1'b1, pmcc_pkg::OFF_CFG, 32'h500);
    cyc(3);
    chk(32'(dram_refresh_clk_en), 32'h0);
    $display("drain test done");
    apb(1'b1, pmcc_pkg::OFF_CFG, 32'h0);
    for (int rf = 0; rf < 4; rf++) begin
      apb(1'b1, pmcc_pkg::OFF_CFG, 32'(rf));
      cyc(3);
      c_irc = 0;
      c_tmr = 0;
      c_cnt = 0;
      c_ref = 0;
      c_ser = 0;
      c_par = 0;
      c_bd = 0;
      repeat (16) begin
        @(negedge pclk);
        c_irc += int'(irc_clk_en === 1'b1);
        c_tmr += int'(timer_clk_en === 1'b1);
        c_cnt += int'(timer_cnt_clk_en === 1'b1);
        c_ref += int'(dram_refresh_clk_en === 1'b1);
        c_ser += int'(serial_clk_en === 1'b1);
        c_par += int'(parallel_clk_en === 1'b1);
        c_bd += int'(serial_baud_clk_en === 1'b1);
      end
      chk(32'(c_irc), 32'(16 >> rf));
      chk(32'(c_tmr), 32'(8 >> rf));
      chk(32'(c_cnt), 32'h8);
      chk(32'(c_ref), 32'h10);
      chk(32'(c_ser), 32'(8 >> rf));
      chk(32'(c_par), 32'(8 >> rf));
      chk(32'(c_bd), 32'h8);
      $display("rate %0d done", rf);
    end
    wake(12'h100, 3'h1, 1'b0, 1'b1);
    wake(12'h200, 3'h2, 1'b1, 1'b0);
    wake(12'h200, 3'h4, 1'b1, 1'b1);
    wake(12'h100, 3'h2, 1'b0, 1'b1);
    // reset in mid-run ends halt and clears the configuration
    apb(1'b1, pmcc_pkg::OFF_CFG, 32'h100);
    cyc(3);
    chk(32'(halt_active), 32'h1);
    @(posedge pclk);
    presetn <= 1'b0;
    cyc(2);
    chk(32'({pready, system_clock_run, halt_active, doze_active, core_exception_req}), 32'h10);
    @(posedge pclk);
    presetn <= 1'b1;
    cyc(4);
    apb(1'b0, pmcc_pkg::OFF_CFG, 32'h0);
    chk(rd, pmcc_pkg::CFG_RST);
    chk(32'({system_clock_run, halt_active}), 32'h2);
    $display("mid-run reset test done");
    print_verdict();
  end
endmodule : pmcc_top_bench
`default_nettype wire
